// File: dlc_pkg.sv
// Package: constants and types for the diagnostic lamp blink code controller
package dlc_pkg;
    localparam int unsigned DLC_CLK_HZ = 125_000_000;
    // Flash timing in milliseconds
    localparam int unsigned DLC_HI_ON_MS = 600;
    localparam int unsigned DLC_HI_OFF_MS = 600;
    localparam int unsigned DLC_LO_ON_MS = 300;
    localparam int unsigned DLC_LO_OFF_MS = 300;
    localparam int unsigned DLC_DIGIT_GAP_MS = 1000;
    localparam int unsigned DLC_CODE_GAP_MS = 1800;
    localparam int unsigned DLC_CYC_PER_MS = DLC_CLK_HZ / 1000;
    localparam int unsigned DLC_HI_ON_CYC = DLC_HI_ON_MS * DLC_CYC_PER_MS;
    localparam int unsigned DLC_HI_OFF_CYC = DLC_HI_OFF_MS * DLC_CYC_PER_MS;
    localparam int unsigned DLC_LO_ON_CYC = DLC_LO_ON_MS * DLC_CYC_PER_MS;
    localparam int unsigned DLC_LO_OFF_CYC = DLC_LO_OFF_MS * DLC_CYC_PER_MS;
    localparam int unsigned DLC_DIGIT_GAP_CYC = DLC_DIGIT_GAP_MS * DLC_CYC_PER_MS;
    localparam int unsigned DLC_CODE_GAP_CYC = DLC_CODE_GAP_MS * DLC_CYC_PER_MS;
    localparam int unsigned DLC_NUM_CODES = 8;
    localparam int unsigned DLC_ZERO_FLASHES = 10;
    localparam logic DLC_LAMP_RST = 1'b0;

    typedef enum logic [2:0] {
        DLC_IDLE = 3'b000,
        DLC_ON = 3'b001,
        DLC_OFF = 3'b011,
        DLC_DGAP = 3'b010,
        DLC_CGAP = 3'b110
    } dlc_state_e;
endpackage : dlc_pkg

// File: dlc_store_if.sv
// Interface: fault store contents seen by the blink sequencer
interface dlc_store_if #(parameter int N = 8);
    logic [N-1:0] valid;
    logic [N-1:0][15:0] code;
    logic any;
    modport store (output valid, output code, output any);
    modport seq (input valid, input code, input any);
endinterface : dlc_store_if

// File: dlc_fault_store.sv
// Fault store: pending and confirmed slots with two-cycle confirmation
module dlc_fault_store
    import dlc_pkg::*;
#(
    parameter int N = DLC_NUM_CODES
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic det_i,
    input wire logic [$clog2(N)-1:0] det_slot_i,
    input wire logic [15:0] det_code_i,
    input wire logic cycle_end_i,
    input wire logic erase_i,
    dlc_store_if.store st,
    output logic confirmed_o
);
    logic [N-1:0] pend, conf, seen;
    logic [N-1:0][15:0] codes;

    // Detection latched per driving cycle; confirm on second consecutive cycle
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pend <= '0;
            conf <= '0;
            seen <= '0;
            codes <= '0;
        end
        else if (erase_i)
        begin
            // A detection in the erase cycle survives the clear
            pend <= det_i ? (N'(1) << det_slot_i) : '0;
            conf <= '0;
            seen <= det_i ? (N'(1) << det_slot_i) : '0;
            codes <= '0;
            if (det_i)
                codes[det_slot_i] <= det_code_i;
        end
        else
        begin
            if (det_i)
            begin
                seen[det_slot_i] <= 1'b1;
                codes[det_slot_i] <= det_code_i;
                // Only pending from the previous cycle confirms
                if (pend[det_slot_i] && !seen[det_slot_i])
                    conf[det_slot_i] <= 1'b1;
            end
            if (cycle_end_i)
            begin
                pend <= seen | (det_i ? (N'(1) << det_slot_i) : '0);
                seen <= '0;
            end
            else if (det_i)
                pend[det_slot_i] <= 1'b1;
        end
    end

    assign st.valid = pend | conf;
    assign st.code = codes;
    assign st.any = |(pend | conf);
    assign confirmed_o = |conf;
endmodule : dlc_fault_store

// File: dlc_lamp_ctrl.sv
// Top: malfunction lamp controller with bulb check, warning, blink codes, mixture monitor
module dlc_lamp_ctrl
    import dlc_pkg::*;
// Behaviour
// - Normal mode, ignition on, engine stopped: lamp steadily on as bulb check.
// - Normal mode, engine running: lamp off unless a fault is confirmed or a processor or severe fault is present.
// - Warning: lamp on for confirmed fault, processor fault or severe fault, else off.
// - Ordinary faults light the lamp after two consecutive driving cycles.
// - Catalyst-damaging misfire or fail-safe lights the lamp in first cycle.
// - Diagnostic mode, engine stopped: flash stored confirmed and pending codes.
// - Confirmed and pending codes shown together with matching numbers.
// - Four decimal digits as flash counts; zero digit is ten flashes.
// - Top digit flashes: 0.6 s on, 0.6 s off.
// - Lower digit flashes: 0.3 s on, 0.3 s off.
// - Extra 1.0 s off between digits.
// - Lamp off 1.8 s between codes; the code gives 0.3 s flash off plus 1.8 s gap, 2.1 s in all.
// - No stored fault: flash code 0000.
// - Leaving diagnostic mode for normal mode erases stored codes.
// - Erase clears codes, freeze frames, readiness codes, test values, distance; only the fault store is cleared here, the rest is left to erase_o.
// - Diagnostic mode, engine running: lamp shows front oxygen sensor mixture.
// - Closed loop: lean on, rich off; open loop holds last state.
#(
    parameter int N = DLC_NUM_CODES,
    parameter int unsigned HI_ON_CYC = DLC_HI_ON_CYC,
    parameter int unsigned HI_OFF_CYC = DLC_HI_OFF_CYC,
    parameter int unsigned LO_ON_CYC = DLC_LO_ON_CYC,
    parameter int unsigned LO_OFF_CYC = DLC_LO_OFF_CYC,
    parameter int unsigned DIGIT_GAP_CYC = DLC_DIGIT_GAP_CYC,
    parameter int unsigned CODE_GAP_CYC = DLC_CODE_GAP_CYC
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic diag_mode_i,
    input wire logic ignition_i,
    input wire logic engine_run_i,
    input wire logic fault_det_i,
    input wire logic [$clog2(N)-1:0] fault_slot_i,
    input wire logic [15:0] fault_code_i,
    input wire logic cycle_end_i,
    input wire logic severe_i,
    input wire logic cpu_fault_i,
    input wire logic closed_loop_i,
    input wire logic front_exhaust_oxygen_sensor_lean_i,
    output logic fault_warning_lamp_o,
    output logic erase_o
);
    dlc_store_if #(.N(N)) st ();
    logic confirmed;
    logic diag_q;
    logic mix_lamp;
    logic blink_lamp;
    dlc_state_e state;
    logic [31:0] tmr;
    logic [$clog2(N)-1:0] slot;
    logic [1:0] digit;
    logic [3:0] flashes;
    logic [15:0] cur_code;

    ////////////////////////////////////////////////////////////////////////
    // Mode change detection and erase
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            diag_q <= 1'b0;
        else
            diag_q <= diag_mode_i;
    end

    // One-cycle erase pulse clears the fault store here, except a detection in the same cycle, and goes outside on erase_o
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            erase_o <= 1'b0;
        else
            erase_o <= diag_q & ~diag_mode_i;
    end

    dlc_fault_store #(.N(N)) u_store (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .det_i(fault_det_i),
        .det_slot_i(fault_slot_i),
        .det_code_i(fault_code_i),
        .cycle_end_i(cycle_end_i),
        .erase_i(erase_o),
        .st(st),
        .confirmed_o(confirmed)
    );

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [3:0] flash_count(input logic [3:0] d);
        flash_count = (d == 4'h0) ? 4'(DLC_ZERO_FLASHES) : d;
    endfunction : flash_count

    function automatic logic [3:0] digit_of(input logic [15:0] c, input logic [1:0] i);
        digit_of = c[15 - 4*i -: 4];
    endfunction : digit_of

    // Next valid slot after s, wrapping; returns s when none
    function automatic logic [$clog2(N)-1:0] next_slot(input logic [N-1:0] v, input logic [$clog2(N)-1:0] s);
        logic [$clog2(N)-1:0] r;
        r = s;
        for (int k = N - 1; k >= 1; k--)
        begin
            if (v[($clog2(N))'((int'(s) + k) % N)])
                r = ($clog2(N))'((int'(s) + k) % N);
        end
        next_slot = r;
    endfunction : next_slot

    wire blink_en = ignition_i & diag_mode_i & ~engine_run_i;
    wire [3:0] cur_flashes = flash_count(digit_of(cur_code, digit));

    ////////////////////////////////////////////////////////////////////////
    // Blink code sequencer
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state <= DLC_IDLE;
            tmr <= '0;
            slot <= '0;
            digit <= '0;
            flashes <= '0;
            cur_code <= '0;
        end
        else if (!blink_en)
        begin
            state <= DLC_IDLE;
            tmr <= '0;
        end
        else
        begin
            unique case (state)
                DLC_IDLE:
                begin
                    state <= DLC_ON;
                    slot <= next_slot(st.valid, '1);
                    cur_code <= st.any ? st.code[next_slot(st.valid, '1)] : 16'h0000;
                    digit <= '0;
                    flashes <= '0;
                    tmr <= HI_ON_CYC - 1;
                end
                DLC_ON:
                begin
                    if (tmr == 0)
                    begin
                        state <= DLC_OFF;
                        tmr <= (digit == 0) ? HI_OFF_CYC - 1 : LO_OFF_CYC - 1;
                        flashes <= flashes + 4'h1;
                    end
                    else
                        tmr <= tmr - 1;
                end
                DLC_OFF:
                begin
                    if (tmr != 0)
                        tmr <= tmr - 1;
                    else if (flashes != cur_flashes)
                    begin
                        state <= DLC_ON;
                        tmr <= (digit == 0) ? HI_ON_CYC - 1 : LO_ON_CYC - 1;
                    end
                    else if (digit != 2'd3)
                    begin
                        state <= DLC_DGAP;
                        tmr <= DIGIT_GAP_CYC - 1;
                    end
                    else
                    begin
                        state <= DLC_CGAP;
                        tmr <= CODE_GAP_CYC - 1;
                    end
                end
                DLC_DGAP:
                begin
                    if (tmr == 0)
                    begin
                        state <= DLC_ON;
                        digit <= digit + 2'd1;
                        flashes <= '0;
                        tmr <= LO_ON_CYC - 1;
                    end
                    else
                        tmr <= tmr - 1;
                end
                DLC_CGAP:
                begin
                    if (tmr == 0)
                    begin
                        // Advance to next stored code, wrapping forever
                        state <= DLC_ON;
                        slot <= next_slot(st.valid, slot);
                        cur_code <= st.any ? st.code[next_slot(st.valid, slot)] : 16'h0000;
                        digit <= '0;
                        flashes <= '0;
                        tmr <= HI_ON_CYC - 1;
                    end
                    else
                        tmr <= tmr - 1;
                end
                default:
                    state <= DLC_IDLE;
            endcase
        end
    end

    assign blink_lamp = (state == DLC_ON);

    ////////////////////////////////////////////////////////////////////////
    // Mixture monitor: hold last state outside closed loop
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            mix_lamp <= DLC_LAMP_RST;
        else if (closed_loop_i)
            mix_lamp <= front_exhaust_oxygen_sensor_lean_i;
    end

    ////////////////////////////////////////////////////////////////////////
    // Lamp output select
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            fault_warning_lamp_o <= DLC_LAMP_RST;
        else if (!ignition_i)
            fault_warning_lamp_o <= 1'b0;
        else if (!diag_mode_i && !engine_run_i)
            fault_warning_lamp_o <= 1'b1;
        else if (!diag_mode_i)
            fault_warning_lamp_o <= confirmed | cpu_fault_i | severe_i;
        else if (engine_run_i)
            fault_warning_lamp_o <= mix_lamp;
        else
            fault_warning_lamp_o <= blink_lamp;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    bulb_check_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ignition_i && !diag_mode_i && !engine_run_i |=> fault_warning_lamp_o)
        else $error("bulb check lamp not lit");
    warn_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ignition_i && !diag_mode_i && engine_run_i && !confirmed && !cpu_fault_i && !severe_i
        |=> !fault_warning_lamp_o)
        else $error("lamp lit with no fault");
    cpu_warn_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ignition_i && !diag_mode_i && engine_run_i && cpu_fault_i |=> fault_warning_lamp_o)
        else $error("processor fault not shown");
    severe_warn_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ignition_i && !diag_mode_i && engine_run_i && severe_i |=> fault_warning_lamp_o)
        else $error("severe fault not shown");
    erase_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(diag_mode_i) |=> erase_o ##1 !erase_o)
        else $error("erase not pulsed on mode exit");
    erase_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        erase_o && !fault_det_i |=> !st.any)
        else $error("store not cleared by erase");
    mix_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !closed_loop_i |=> $stable(mix_lamp))
        else $error("mixture lamp changed in open loop");
    mix_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
        closed_loop_i |=> mix_lamp == $past(front_exhaust_oxygen_sensor_lean_i))
        else $error("mixture lamp not following sensor");
    flash_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state == DLC_OFF |-> flashes <= 4'(DLC_ZERO_FLASHES))
        else $error("flash count above ten");
    gap_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        blink_en && state == DLC_DGAP && $changed(state) |-> tmr == DIGIT_GAP_CYC - 1)
        else $error("digit gap length wrong");

    ////////////////////////////////////////////////////////////////////////
    // Lamp source selection and sequencer abort
    lamp_dark_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ignition_i |=> !fault_warning_lamp_o)
        else $error("lamp lit with ignition off");
    warn_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ignition_i && !diag_mode_i && engine_run_i && confirmed |=> fault_warning_lamp_o)
        else $error("confirmed fault not shown");
    blink_show_a: assert property (@(posedge clk_i) disable iff (rst_i)
        blink_en |=> fault_warning_lamp_o == $past(blink_lamp))
        else $error("lamp not following code display");
    mix_show_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ignition_i && diag_mode_i && engine_run_i |=> fault_warning_lamp_o == $past(mix_lamp))
        else $error("lamp not following mixture monitor");
    blink_abort_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !blink_en |=> state == DLC_IDLE)
        else $error("sequencer running outside code display");

    // Flash timing and sequencing
    hi_on_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        blink_en && state == DLC_ON && $changed(state) && digit == 2'd0
        |-> tmr == HI_ON_CYC - 1)
        else $error("top digit on time wrong");
    lo_on_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        blink_en && state == DLC_ON && $changed(state) && digit != 2'd0
        |-> tmr == LO_ON_CYC - 1)
        else $error("lower digit on time wrong");
    hi_off_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        blink_en && state == DLC_OFF && $changed(state) && digit == 2'd0
        |-> tmr == HI_OFF_CYC - 1)
        else $error("top digit off time wrong");
    lo_off_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        blink_en && state == DLC_OFF && $changed(state) && digit != 2'd0
        |-> tmr == LO_OFF_CYC - 1)
        else $error("lower digit off time wrong");
    code_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        blink_en && state == DLC_CGAP && $changed(state)
        |-> tmr == CODE_GAP_CYC - 1 && digit == 2'd3)
        else $error("code gap wrong");
    digit_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
        blink_en && (state == DLC_DGAP || state == DLC_CGAP) && $changed(state)
        |-> flashes == cur_flashes)
        else $error("digit ended with wrong flash count");
    flash_dark_a: assert property (@(posedge clk_i) disable iff (rst_i)
        blink_en && state != DLC_ON |=> !fault_warning_lamp_o)
        else $error("lamp lit between flashes");
    digit_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
        blink_en && state == DLC_DGAP && tmr == 0
        |=> state == DLC_ON && digit == $past(digit) + 2'd1)
        else $error("digit not advanced after gap");
    code_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        blink_en && state == DLC_CGAP && tmr == 0
        |=> state == DLC_ON && digit == 2'd0)
        else $error("next code not started after gap");
    zero_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
        blink_en && state == DLC_IDLE && !st.any |=> cur_code == 16'h0000)
        else $error("empty store not shown as zero code");

    // Erase pulse shape and cause
    erase_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
        erase_o |=> !erase_o)
        else $error("erase longer than one cycle");
    erase_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
        erase_o |-> !$past(diag_mode_i) && $past(diag_mode_i, 2))
        else $error("erase without leaving diagnostic mode");

    blink_run_c: cover property (@(posedge clk_i) disable iff (rst_i) blink_en && state == DLC_CGAP);
    confirm_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(confirmed));
    erase_c: cover property (@(posedge clk_i) disable iff (rst_i) erase_o);
    zero_code_c: cover property (@(posedge clk_i) disable iff (rst_i) blink_en && state == DLC_IDLE && !st.any);
    mix_show_c: cover property (@(posedge clk_i) disable iff (rst_i) ignition_i && diag_mode_i && engine_run_i);
endmodule : dlc_lamp_ctrl

// File: dlc_lamp_watch.sv
// Lamp observer: reports each finished on or off run and its length in cycles
module dlc_lamp_watch
    import dlc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic lamp_i,
    output logic run_done_o,
    output logic run_level_o,
    output logic [15:0] run_len_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic prev;
    logic [15:0] cnt;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            prev <= DLC_LAMP_RST;
            cnt <= 16'h0001;
            run_done_o <= 1'b0;
            run_level_o <= 1'b0;
            run_len_o <= 16'h0000;
        end
        else
        begin
            run_done_o <= (lamp_i != prev);
            prev <= lamp_i;
            if (lamp_i != prev)
            begin
                run_level_o <= prev;
                run_len_o <= cnt;
                cnt <= 16'h0001;
            end
            else
                cnt <= cnt + 16'h0001;
        end
    end
endmodule : dlc_lamp_watch

// File: dlc_lamp_ctrl_test.sv
// Testbench: lamp modes, two-cycle confirmation, blink codes, erase, mixture
module dlc_lamp_ctrl_test
    import dlc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned P_HI_ON = 4;
    localparam int unsigned P_HI_OFF = 4;
    localparam int unsigned P_LO_ON = 2;
    localparam int unsigned P_LO_OFF = 2;
    localparam int unsigned P_DGAP = 6;
    localparam int unsigned P_CGAP = 10;
    localparam int CEIL = 20000;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic diag = 1'b0, ign = 1'b0, eng = 1'b0, det = 1'b0, cend = 1'b0;
    logic sev = 1'b0, cpu = 1'b0, closed = 1'b0, lean = 1'b0;
    logic [2:0] slot = 3'h0;
    logic [15:0] code = 16'h0000;
    logic lamp, erase, run_done, run_level;
    logic [15:0] run_len;
    int miscompares = 0;
    int n_compared = 0;
    int cycles = 0;

    dlc_lamp_ctrl #(.N(8), .HI_ON_CYC(P_HI_ON), .HI_OFF_CYC(P_HI_OFF), .LO_ON_CYC(P_LO_ON),
        .LO_OFF_CYC(P_LO_OFF), .DIGIT_GAP_CYC(P_DGAP), .CODE_GAP_CYC(P_CGAP)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .diag_mode_i(diag), .ignition_i(ign), .engine_run_i(eng),
        .fault_det_i(det), .fault_slot_i(slot), .fault_code_i(code), .cycle_end_i(cend),
        .severe_i(sev), .cpu_fault_i(cpu), .closed_loop_i(closed),
        .front_exhaust_oxygen_sensor_lean_i(lean), .fault_warning_lamp_o(lamp), .erase_o(erase));
    dlc_lamp_watch u_watch (.clk_i(clk_i), .rst_i(rst_i), .lamp_i(lamp), .run_done_o(run_done),
        .run_level_o(run_level), .run_len_o(run_len));

    initial
    begin
        forever #4 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc

    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    task automatic cmp_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic cmp_run(input logic [16:0] got, input logic [16:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t run got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_run

    // Next finished lamp run, bounded wait
    task automatic wait_run(input logic lvl, input int unsigned len);
        int k;
        for (k = 0; k < 300 && run_done !== 1'b1; k++)
            cyc(1);
        cmp_run({run_level, run_len}, {lvl, len[15:0]});
        cyc(1);
    endtask : wait_run

    task automatic expect_code(input logic [15:0] c);
        int d, n, i;
        for (d = 3; d >= 0; d--)
        begin
            n = c[d*4+:4];
            if (n == 0)
                n = DLC_ZERO_FLASHES;
            for (i = 0; i < n; i++)
            begin
                wait_run(1'b1, d == 3 ? P_HI_ON : P_LO_ON);
                wait_run(1'b0, (d == 3 ? P_HI_OFF : P_LO_OFF)
                    + (i < n - 1 ? 0 : (d == 0 ? P_CGAP : P_DGAP)));
            end
        end
    endtask : expect_code

    // Dark lamp first, then ignition on so the first off run ends at the first flash
    task automatic enter_blink();
        int k;
        @(posedge clk_i);
        ign <= 1'b0;
        eng <= 1'b0;
        diag <= 1'b1;
        cyc(5);
        @(posedge clk_i);
        ign <= 1'b1;
        for (k = 0; k < 50 && !(run_done === 1'b1 && run_level === 1'b0); k++)
            cyc(1);
        cyc(1);
    endtask : enter_blink

    task automatic pulse(input logic is_det, input logic [2:0] s, input logic [15:0] c);
        @(posedge clk_i);
        det <= is_det;
        cend <= ~is_det;
        slot <= s;
        code <= c;
        @(posedge clk_i);
        det <= 1'b0;
        cend <= 1'b0;
        cyc(1);
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_normal();
        @(posedge clk_i);
        ign <= 1'b1;
        cyc(3);
        cmp_bit(lamp, 1'b1);
        @(posedge clk_i);
        eng <= 1'b1;
        cyc(3);
        cmp_bit(lamp, 1'b0);
        @(posedge clk_i);
        cpu <= 1'b1;
        cyc(3);
        cmp_bit(lamp, 1'b1);
        @(posedge clk_i);
        cpu <= 1'b0;
        sev <= 1'b1;
        cyc(3);
        cmp_bit(lamp, 1'b1);
        @(posedge clk_i);
        sev <= 1'b0;
        cyc(3);
        cmp_bit(lamp, 1'b0);
    endtask : t_normal

    task automatic t_two_trip();
        pulse(1'b1, 3'h2, 16'h1023);
        pulse(1'b1, 3'h2, 16'h1023);
        cyc(2);
        cmp_bit(lamp, 1'b0);
        pulse(1'b0, 3'h0, 16'h0000);
        pulse(1'b1, 3'h2, 16'h1023);
        pulse(1'b1, 3'h5, 16'h0301);
        cyc(2);
        cmp_bit(lamp, 1'b1);
    endtask : t_two_trip

    task automatic t_codes();
        enter_blink();
        expect_code(16'h1023);
        expect_code(16'h0301);
        expect_code(16'h1023);
    endtask : t_codes

    task automatic t_erase();
        int k;
        @(posedge clk_i);
        diag <= 1'b0;
        for (k = 0; k < 4 && erase !== 1'b1; k++)
            cyc(1);
        cmp_bit(erase, 1'b1);
        cyc(1);
        cmp_bit(erase, 1'b0);
        enter_blink();
        expect_code(16'h0000);
        expect_code(16'h0000);
    endtask : t_erase

    task automatic t_mixture();
        @(posedge clk_i);
        eng <= 1'b1;
        closed <= 1'b1;
        lean <= 1'b1;
        cyc(4);
        cmp_bit(lamp, 1'b1);
        @(posedge clk_i);
        lean <= 1'b0;
        cyc(4);
        cmp_bit(lamp, 1'b0);
        @(posedge clk_i);
        lean <= 1'b1;
        cyc(4);
        @(posedge clk_i);
        closed <= 1'b0;
        cyc(1);
        @(posedge clk_i);
        lean <= 1'b0;
        cyc(4);
        cmp_bit(lamp, 1'b1);
    endtask : t_mixture

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == CEIL)
        begin
            miscompares++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        cyc(2);
        cmp_bit(lamp, 1'b0);
        t_normal();
        t_two_trip();
        t_codes();
        t_erase();
        t_mixture();
        print_verdict();
    end
endmodule : dlc_lamp_ctrl_test
